// ==== dv/ppd_line_card.sv ====
module ppd_line_card (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Divider outputs, A at bit 0
  input wire logic [3:0] outs,
  // Last high and low run lengths in clocks
  output logic [15:0] hi_len [4],
  output logic [15:0] lo_len [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run [4];
  logic [3:0] prev;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        run[i] <= 16'h0001;
        hi_len[i] <= 16'h0000;
        lo_len[i] <= 16'h0000;
      end
    end else begin
      prev <= outs;
      for (int i = 0; i < 4; i++) begin
        if (outs[i] != prev[i]) begin
          if (prev[i]) begin
            hi_len[i] <= run[i];
          end else begin
            lo_len[i] <= run[i];
          end
          run[i] <= 16'h0001;
        end else begin
          run[i] <= run[i] + 16'h0001;
        end
      end
    end
  end
endmodule : ppd_line_card

// ==== dv/ppd_monitor.sv ====
module ppd_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Phase controls
  input wire logic [7:0] first_synth_phase_advance,
  input wire logic [7:0] second_synth_phase_advance,
  input wire logic [7:0] third_synth_phase_advance,
  input wire logic [7:0] fourth_synth_phase_advance
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bank_q;
  logic [31:0] phase_all;

  assign phase_all = {first_synth_phase_advance, second_synth_phase_advance,
                      third_synth_phase_advance, fourth_synth_phase_advance};

  // Shadow of the bank bit, needed to decode the 8-bit location
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bank_q <= 1'b0;
    end else if (reg_wr && reg_addr == 7'h7f) begin
      bank_q <= reg_wdata[0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read valid");
  a_rdata_held: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
  a_phase_first: assert property (reg_wr && !bank_q && reg_addr == 7'h78 |=>
    first_synth_phase_advance == $past(reg_wdata)) else $error("phase 0 not written");
  a_phase_fourth: assert property (reg_wr && !bank_q && reg_addr == 7'h7b |=>
    fourth_synth_phase_advance == $past(reg_wdata)) else $error("phase 3 not written");
  a_phase_stable: assert property (!$past(reg_wr) |-> $stable(phase_all)) else $error("phase moved");
  a_upper_no_phase: assert property (reg_wr && bank_q && reg_addr == 7'h78 |=> $stable(phase_all))
    else $error("upper write hit phase");
  a_bank_readback: assert property (reg_rd && reg_addr == 7'h7f |=> reg_rdata == {7'h00, $past(bank_q)})
    else $error("bank read wrong");
  a_unmapped_zero: assert property (reg_rd && !bank_q && reg_addr == 7'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : ppd_monitor

bind ppd_top ppd_monitor ppd_monitor_inst (.clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rvalid, .first_synth_phase_advance, .second_synth_phase_advance,
  .third_synth_phase_advance, .fourth_synth_phase_advance);

// ==== dv/ppd_top_tb.sv ====
module ppd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic c_pin = 1'b0;
  logic d_pin = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [7:0] ph [4];
  logic [3:0] outs;
  logic [15:0] hi_len [4];
  logic [15:0] lo_len [4];
  int fail_count = 0;
  int checks = 0;

  always #2.5 clock = ~clock;

  ppd_top ppd_top_inst (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .c_on_config_pins(c_pin),
    .d_on_config_pins(d_pin), .first_synth_phase_advance(ph[0]), .second_synth_phase_advance(ph[1]),
    .third_synth_phase_advance(ph[2]), .fourth_synth_phase_advance(ph[3]), .divider_a_out(outs[0]),
    .divider_b_out(outs[1]), .divider_c_out(outs[2]), .divider_d_out(outs[3]));
  ppd_line_card ppd_line_card_inst (.clock(clock), .rst(rst), .outs(outs), .hi_len(hi_len), .lo_len(lo_len));

  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Most significant byte sits at the lowest location
  task automatic wr24(input logic [6:0] a, input logic [23:0] d);
    wr(a, d[23:16]);
    wr(a + 7'h01, d[15:8]);
    wr(a + 7'h02, d[7:0]);
  endtask : wr24

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk({23'h0, reg_rvalid}, 24'h000001);
    chk({16'h0, reg_rdata}, {16'h0, e});
  endtask : rd_chk

  task automatic runs(input int i, input logic [15:0] h, input logic [15:0] l);
    repeat (500) @(posedge clock);
    #1;
    chk({8'h0, hi_len[i]}, {8'h0, h});
    chk({8'h0, lo_len[i]}, {8'h0, l});
  endtask : runs

  // Cycles from the last rise of the related output to the next rise of the pulse
  task automatic lag_chk(input int i, input int rel, input logic [15:0] exp);
    logic [3:0] last;
    logic [15:0] gap;
    logic seen;
    logic found;
    last = outs;
    gap = 16'h0000;
    seen = 1'b0;
    found = 1'b0;
    for (int n = 0; n < 200; n++) begin
      @(posedge clock);
      #1;
      if (outs[rel] && !last[rel]) begin
        gap = 16'h0000;
        seen = 1'b1;
      end else begin
        gap = gap + 16'h0001;
      end
      if (seen && outs[i] && !last[i]) begin
        found = 1'b1;
        break;
      end
      last = outs;
    end
    if (!found) gap = 16'hffff;
    chk({8'h0, gap}, {8'h0, exp});
  endtask : lag_chk

  task automatic test_reset_regs();
    rd_chk(7'h7f, 8'h00);
    for (int i = 0; i < 4; i++) rd_chk(7'h78 + 7'(i), 8'h00);
    rd_chk(7'h10, 8'h00);
    wr(7'h7f, 8'h01);
    rd_chk(7'h7f, 8'h01);
    rd_chk(7'h02, 8'h02);
    rd_chk(7'h08, 8'h40);
    runs(0, 16'd1, 16'd1);
    runs(2, 16'd32, 16'd32);
  endtask : test_reset_regs

  task automatic test_phase();
    wr(7'h7f, 8'h00);
    for (int i = 0; i < 4; i++) wr(7'h78 + 7'(i), 8'h11 * 8'(i + 1));
    #1;
    for (int i = 0; i < 4; i++) chk({16'h0, ph[i]}, {16'h0, 8'h11 * 8'(i + 1)});
    wr(7'h7f, 8'h01);
    wr(7'h78, 8'hff);
    #1;
    chk({16'h0, ph[0]}, 24'h000011);
    rd_chk(7'h78, 8'h00);
  endtask : test_phase

  task automatic test_divs();
    wr24(7'h00, 24'h000005);
    wr24(7'h03, 24'h000008);
    wr24(7'h06, 24'h000029);
    runs(0, 16'd2, 16'd3);
    runs(1, 16'd4, 16'd4);
    runs(2, 16'd20, 16'd21);
  endtask : test_divs

  task automatic test_frame_d();
    logic [15:0] r [3] = '{16'd5, 16'd8, 16'd6};
    wr24(7'h06, 24'h000006);
    for (int s = 0; s < 3; s++) begin
      d_pin <= s[0];
      wr24(7'h09, {4'hf, 2'b00, 2'(s), 16'h0003});
      if (s == 1) runs(3, 2 * r[s], r[s]);
      else runs(3, r[s], 2 * r[s]);
    end
    d_pin <= 1'b0;
  endtask : test_frame_d

  task automatic test_frame_c();
    logic [1:0] sel [6] = '{2'b00, 2'b01, 2'b11, 2'b00, 2'b01, 2'b11};
    logic [15:0] r [6] = '{16'd5, 16'd8, 16'd4, 16'd5, 16'd8, 16'd4};
    // Pulse rise after related rise; used only where the pulse is not inverted
    logic [15:0] lag [6] = '{16'd4, 16'd0, 16'd2, 16'd2, 16'd0, 16'd0};
    logic pol;
    wr24(7'h09, 24'h000004);
    for (int k = 0; k < 6; k++) begin
      pol = (k > 2);
      c_pin <= k[0];
      wr24(7'h06, {4'hf, k[1], pol, sel[k], 16'h0003});
      if (pol ^ k[0]) runs(2, 2 * r[k], r[k]);
      else runs(2, r[k], 2 * r[k]);
      if (!(pol ^ k[0])) lag_chk(2, int'(sel[k]), lag[k]);
    end
    c_pin <= 1'b0;
  endtask : test_frame_c

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    test_reset_regs();
    test_phase();
    test_divs();
    test_frame_d();
    test_frame_c();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
endmodule : ppd_top_tb

// ==== rtl/ppd_divider.sv ====
module ppd_divider #(
  parameter int unsigned W = 24,
  parameter logic [W-1:0] RESET_RATIO = W'(2)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requested ratio
  input wire logic [W-1:0] ratio,
  // Divided clock and its period start
  output logic level,
  output logic period_start
);

  logic [W-1:0] held;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic [W-1:0] next_ratio;
  logic wrap;

  always_comb begin
    wrap = (cnt >= held - W'(1));
    next_cnt = wrap ? '0 : cnt + W'(1);
    if (!wrap)
      next_ratio = held;
    else if (ratio < W'(ppd_pkg::MIN_RATIO))
      next_ratio = W'(ppd_pkg::MIN_RATIO);
    else
      next_ratio = ratio;
  end

  // New ratio taken only when a period ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held <= RESET_RATIO;
      cnt <= '0;
    end else begin
      held <= next_ratio;
      cnt <= next_cnt;
    end
  end

  // High for the first half, so even ratios give exactly 50%
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
      period_start <= 1'b0;
    end else begin
      level <= (next_cnt < (next_ratio >> 1));
      period_start <= wrap;
    end
  end

endmodule : ppd_divider

// ==== rtl/ppd_frame_pulse.sv ====
module ppd_frame_pulse #(
  parameter int unsigned CW = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Related clock
  input wire logic rel_valid,
  input wire logic rel_level,
  input wire logic rel_start,
  // Settings
  input wire logic [CW-1:0] period_count,
  input wire logic invert_pol,
  input wire logic edge_style,
  input wire logic pin_invert,
  // Pulse and frame boundary
  output logic pulse,
  output logic frame_start
);

  logic [CW-1:0] held_count;
  logic [CW-1:0] frame_cnt;
  logic held_pol;
  logic held_style;
  logic rel_level_d;
  logic boundary;
  logic first_period;
  logic last_period;
  logic active;

  always_comb begin
    boundary = rel_valid && rel_start && (frame_cnt >= held_count - CW'(1));
    first_period = (frame_cnt == '0);
    last_period = (frame_cnt >= held_count - CW'(1));
    // Edge style: pulse fills the first related period
    // Straddle style: second half of last period and first half of the next
    if (held_style)
      active = first_period;
    else
      active = (first_period && rel_level_d) || (last_period && !rel_level_d);
  end

  // Related periods counted between frame pulses
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      frame_cnt <= '0;
    else if (rel_valid && rel_start)
      frame_cnt <= boundary ? '0 : frame_cnt + CW'(1);
  end

  // Settings other than pin_invert change only at a frame boundary
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held_count <= CW'(1);
      held_pol <= 1'b0;
      held_style <= 1'b0;
    end else if (boundary) begin
      held_count <= (period_count == '0) ? CW'(1) : period_count;
      held_pol <= invert_pol;
      held_style <= edge_style;
    end
  end

  // Level delayed to line up with the counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rel_level_d <= 1'b0;
      pulse <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      rel_level_d <= rel_level;
      pulse <= (rel_valid && active) ^ held_pol ^ pin_invert;
      frame_start <= boundary;
    end
  end

endmodule : ppd_frame_pulse

// ==== rtl/ppd_pkg.sv ====
package ppd_pkg;

  // Register offsets in the 8-bit map
  localparam logic [7:0] OFS_PHASE [4] = '{8'h78, 8'h79, 8'h7a, 8'h7b};
  localparam logic [7:0] OFS_BANK = 8'h7f;
  localparam logic [7:0] OFS_RATIO [4] = '{8'h80, 8'h83, 8'h86, 8'h89};
  localparam logic [6:0] BANK_ADDR7 = 7'h7f;
  localparam logic [7:0] UPPER_TOP = 8'hfb;

  // Reset values
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic RST_BANK = 1'b0;
  localparam logic [23:0] RST_RATIO_AB = 24'h000002;
  localparam logic [23:0] RST_RATIO_CD = 24'h000040;

  // Field layout of the divider registers
  localparam int unsigned RATIO_W = 24;
  localparam int unsigned AB_RATIO_HI = 22;
  localparam int unsigned MODE_HI = 23;
  localparam int unsigned MODE_LO = 20;
  localparam logic [3:0] MODE_FRAME = 4'hf;
  localparam int unsigned STYLE_BIT = 19;
  localparam int unsigned POL_BIT = 18;
  localparam int unsigned SEL_HI = 17;
  localparam int unsigned SEL_LO = 16;
  localparam int unsigned COUNT_W = 16;

  // Smallest ratio that a 50% divider can realise on one clock
  localparam logic [23:0] MIN_RATIO = 24'h000002;

  typedef enum logic [1:0] {
    PPD_DIV_A,
    PPD_DIV_B,
    PPD_DIV_C,
    PPD_DIV_D
  } ppd_div_t;

endpackage : ppd_pkg

// ==== rtl/ppd_top.sv ====
module ppd_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Frame pulse routed to configurable output pins
  input wire logic c_on_config_pins,
  input wire logic d_on_config_pins,
  // Synthesizer phase shifter controls
  output logic [7:0] first_synth_phase_advance,
  output logic [7:0] second_synth_phase_advance,
  output logic [7:0] third_synth_phase_advance,
  output logic [7:0] fourth_synth_phase_advance,
  // Post-divider outputs
  output logic divider_a_out,
  output logic divider_b_out,
  output logic divider_c_out,
  output logic divider_d_out
);

  localparam int unsigned RW = ppd_pkg::RATIO_W;
  localparam int unsigned CW = ppd_pkg::COUNT_W;

  logic [7:0] phase [4];
  logic bank;
  logic [RW-1:0] ratio [4];
  logic [7:0] full_addr;
  logic [7:0] next_rdata;
  logic [3:0] div_level;
  logic [3:0] div_start;
  logic [3:0] out_q;
  logic [1:0] frame_mode;
  logic [1:0] frame_level;
  logic [1:0] frame_start;

  // Byte lane of a 24-bit register hit by an address; 3 means miss.
  // The lowest address holds the most significant byte.
  function automatic logic [1:0] ppd_lane(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    ppd_lane = (diff < 8'h03) ? 2'h2 - diff[1:0] : 2'h3;
  endfunction : ppd_lane

  // Related clock of a frame divider; selecting itself is reserved
  function automatic logic ppd_rel_ok(input logic [1:0] sel, input ppd_pkg::ppd_div_t own);
    ppd_rel_ok = (sel != 2'(own));
  endfunction : ppd_rel_ok

  // Mode field all ones selects frame pulses
  function automatic logic ppd_is_frame(input logic [RW-1:0] r);
    ppd_is_frame = (r[ppd_pkg::MODE_HI:ppd_pkg::MODE_LO] == ppd_pkg::MODE_FRAME);
  endfunction : ppd_is_frame

  // Address 0x7f reaches the bank register from either half
  assign full_addr = (reg_addr == ppd_pkg::BANK_ADDR7) ? ppd_pkg::OFS_BANK : {bank, reg_addr};

  // Bank select register; bits 7:1 are not stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      bank <= ppd_pkg::RST_BANK;
    else if (reg_wr && full_addr == ppd_pkg::OFS_BANK)
      bank <= reg_wdata[0];
  end

  // Phase advance registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++)
        phase[i] <= ppd_pkg::RST_PHASE;
    end else if (reg_wr) begin
      for (int i = 0; i < 4; i++)
        if (full_addr == ppd_pkg::OFS_PHASE[i])
          phase[i] <= reg_wdata;
    end
  end

  // Divider ratio registers, one byte per access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++)
        ratio[i] <= (i < 2) ? ppd_pkg::RST_RATIO_AB : ppd_pkg::RST_RATIO_CD;
    end else if (reg_wr) begin
      for (int i = 0; i < 4; i++)
        if (ppd_lane(full_addr, ppd_pkg::OFS_RATIO[i]) != 2'h3)
          ratio[i][{ppd_lane(full_addr, ppd_pkg::OFS_RATIO[i]), 3'b000} +: 8] <= reg_wdata;
    end
  end

  // Read mux; unmapped locations read zero
  always_comb begin
    next_rdata = 8'h00;
    if (full_addr == ppd_pkg::OFS_BANK)
      next_rdata = {7'h00, bank};
    for (int i = 0; i < 4; i++) begin
      if (full_addr == ppd_pkg::OFS_PHASE[i])
        next_rdata = phase[i];
      if (full_addr <= ppd_pkg::UPPER_TOP && ppd_lane(full_addr, ppd_pkg::OFS_RATIO[i]) != 2'h3)
        next_rdata = ratio[i][{ppd_lane(full_addr, ppd_pkg::OFS_RATIO[i]), 3'b000} +: 8];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // Phase fields go straight to the synthesizer phase shifters,
  // which move every clock of that synthesizer, post-dividers included
  assign first_synth_phase_advance = phase[0];
  assign second_synth_phase_advance = phase[1];
  assign third_synth_phase_advance = phase[2];
  assign fourth_synth_phase_advance = phase[3];

  // Four post-dividers; A and B ignore bit 23
  for (genvar i = 0; i < 4; i++) begin : g_div
    logic [RW-1:0] div_ratio;
    if (i < 2) begin : g_ab
      assign div_ratio = {1'b0, ratio[i][ppd_pkg::AB_RATIO_HI:0]};
    end else begin : g_cd
      // In frame mode the divider idles at the shortest ratio, so that a
      // return to clock mode is not held up by a frame-sized count
      assign div_ratio = ppd_is_frame(ratio[i]) ? RW'(ppd_pkg::MIN_RATIO) : ratio[i];
    end
    ppd_divider #(
      .W(RW),
      .RESET_RATIO((i < 2) ? ppd_pkg::RST_RATIO_AB : ppd_pkg::RST_RATIO_CD)
    ) u_div (
      .clock(clock),
      .rst(rst),
      .ratio(div_ratio),
      .level(div_level[i]),
      .period_start(div_start[i])
    );
  end

  // Frame pulse stages for dividers C and D
  for (genvar j = 0; j < 2; j++) begin : g_frame
    logic [1:0] sel;
    logic rel_ok;
    logic pin_inv;
    logic req_frame;
    assign sel = ratio[j + 2][ppd_pkg::SEL_HI:ppd_pkg::SEL_LO];
    assign rel_ok = ppd_rel_ok(sel, ppd_pkg::ppd_div_t'(j + 2));
    assign pin_inv = (j == 0) ? c_on_config_pins : d_on_config_pins;
    assign req_frame = ppd_is_frame(ratio[j + 2]);

    ppd_frame_pulse #(
      .CW(CW)
    ) u_frame (
      .clock(clock),
      .rst(rst),
      .rel_valid(rel_ok),
      .rel_level(div_level[sel]),
      .rel_start(div_start[sel]),
      .period_count(ratio[j + 2][CW-1:0]),
      .invert_pol(ratio[j + 2][ppd_pkg::POL_BIT]),
      .edge_style(ratio[j + 2][ppd_pkg::STYLE_BIT]),
      .pin_invert(pin_inv),
      .pulse(frame_level[j]),
      .frame_start(frame_start[j])
    );

    // Mode switches at the end of the running period or frame
    always_ff @(posedge clock or posedge rst) begin
      if (rst)
        frame_mode[j] <= 1'b0;
      else if (frame_mode[j] ? frame_start[j] : div_start[j + 2])
        frame_mode[j] <= req_frame;
    end
  end

  // Every output pin from a flip-flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_q <= 4'h0;
    end else begin
      out_q[1:0] <= div_level[1:0];
      for (int k = 0; k < 2; k++)
        out_q[k + 2] <= frame_mode[k] ? frame_level[k] : div_level[k + 2];
    end
  end

  assign divider_a_out = out_q[0];
  assign divider_b_out = out_q[1];
  assign divider_c_out = out_q[2];
  assign divider_d_out = out_q[3];

endmodule : ppd_top
